// File: lpd_panel_timing.sv
// Drive timing generator for a passive matrix panel with cascaded column and row drivers.
//
// Function
// [R1] Reset returns all internal state to defaults.
// [R2] Reset drives every output inactive.
// [R3] Column data leaves on a 4-bit bus.
// [R4] Data is stable at each shift falling edge.
// [R5] Shift clock idles from latch to next line.
// [R6] Enable chain falls after every 16 shifts.
// [R7] Latch pulse follows a fully shifted line.
// [R8] One latch pulse per line, doubles row clock.
// [R9] Bias toggles at the configured line period.
// [R10] Row clock falling edge captures frame pulse.
// [R11] Frame pulse high during last line.
// [R12] Row drivers pass the frame pulse along.
// [R13] Disable stays high while display drives.
// [R14] Power save lowers disable within two frames.
// [R15] Disable is low during reset.
// [R16] Scan and test inputs are held low.
// [R17] Strap selects shift ratio 4, 8 or 16.
// [R18] Enable cascade restarts at each line start.
`timescale 1ns/1ps
`include "lpd_params.svh"

module lpd_panel_timing #(
  parameter int COLS = `LPD_COLS_DEFAULT,
  parameter int LINES = `LPD_LINES_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [1:0] strap_config,
  input wire logic scan_test_enable_in,
  input wire logic test_mode_enable_in,
  input wire lpd_pkg::lpd_config_type config_in,
  input wire logic [3:0] pixel_nibble,
  output logic pixel_take,
  output lpd_pkg::lpd_panel_type panel
);
  import lpd_pkg::*;

  // The reserved scan and test pins are expected tied low and are not read.
  // [R16]

  // Counter widths leave room for the count one past the last column and line.
  localparam int CW = $clog2(COLS + 1);
  localparam int LW = $clog2(LINES + 1);

  function automatic logic [3:0] half_count(input logic [1:0] code);
    case (code)
      `LPD_STRAP_DIV4: half_count = `LPD_HALF_DIV4;
      `LPD_STRAP_DIV8: half_count = `LPD_HALF_DIV8;
      `LPD_STRAP_DIV16: half_count = `LPD_HALF_DIV16;
      // The reserved code runs at the slowest ratio, the safest guess for an unknown panel.
      default: half_count = `LPD_HALF_DIV16;
    endcase
  endfunction : half_count

  // Straps come from pins, so they pass two flip-flops first.
  logic [1:0] strap_meta_q;
  logic [1:0] strap_sync_q;

  lpd_state_type state_q, state_d;
  logic [3:0] div_q, div_d;
  logic half_b_q, half_b_d;
  logic [CW-1:0] col_q, col_d;
  logic [LW-1:0] line_q, line_d;
  logic [7:0] bias_cnt_q, bias_cnt_d;
  logic [1:0] save_frames_q, save_frames_d;
  lpd_panel_type panel_q, panel_d;
  logic take_q, take_d;

  logic [3:0] half_len;
  logic half_end;
  logic last_line;
  logic [7:0] bias_limit;
  logic group_end;
  logic col_last;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_meta_q <= `LPD_STRAP_DIV4;
      strap_sync_q <= `LPD_STRAP_DIV4;
    end else if (clk_en) begin
      strap_meta_q <= strap_config;
      strap_sync_q <= strap_meta_q;
    end
  end

  // Every step of the line sequence below happens at the end of a shift half period.
  always_comb begin
    half_len = half_count(strap_sync_q); // [R17]
    // A strap change to a faster ratio ends the running half period at once.
    // Without this the divider would wrap through its whole range and stretch one half period.
    half_end = (div_q >= half_len - 4'h1);
    last_line = (line_q == LW'(LINES - 1));
    bias_limit = (config_in.bias_period == 8'h00) ? 8'h01 : config_in.bias_period;
    group_end = ((col_q % CW'(`LPD_ENABLE_GROUP)) == CW'(`LPD_ENABLE_GROUP - 1));
    col_last = (col_q == CW'(COLS - 1));

    state_d = state_q;
    div_d = half_end ? 4'h0 : div_q + 4'h1;
    half_b_d = half_end ? ~half_b_q : half_b_q;
    col_d = col_q;
    line_d = line_q;
    bias_cnt_d = bias_cnt_q;
    save_frames_d = save_frames_q;
    panel_d = panel_q;
    take_d = 1'b0;

    if (half_end) begin
      case (state_q)
        LPD_ST_START: begin
          // The enable cascade is reloaded before the first nibble of every line.
          if (!half_b_q) begin
            panel_d.column_enable_chain_clock = 1'b1; // [R18]
            panel_d.frame_row_pulse = last_line; // [R11]
          end else begin
            panel_d.column_enable_chain_clock = 1'b0; // [R18]
            state_d = LPD_ST_SHIFT;
            col_d = '0;
          end
        end
        LPD_ST_SHIFT: begin
          if (!half_b_q) begin
            // Data changes only while the shift clock is high, a half period before its fall.
            panel_d.column_data_out = pixel_nibble; // [R3] [R4]
            panel_d.column_shift_clock = 1'b1;
            take_d = 1'b1;
            panel_d.column_enable_chain_clock = 1'b0;
          end else begin
            panel_d.column_shift_clock = 1'b0; // [R4]
            panel_d.column_enable_chain_clock = group_end; // [R6]
            if (col_last) begin
              state_d = LPD_ST_LATCH; // [R7]
            end else begin
              col_d = col_q + CW'(1);
            end
          end
        end
        LPD_ST_LATCH: begin
          // The shift clock stays low here, which saves driver power between lines.
          panel_d.column_shift_clock = 1'b0; // [R5]
          if (!half_b_q) begin
            panel_d.column_enable_chain_clock = 1'b0;
            panel_d.line_latch_pulse = 1'b1; // [R7] [R8]
            panel_d.row_shift_clock = 1'b1; // [R10]
          end else begin
            panel_d.line_latch_pulse = 1'b0; // [R8]
            panel_d.row_shift_clock = 1'b0; // [R10]
            state_d = LPD_ST_START;
            if (bias_cnt_q + 8'h01 >= bias_limit) begin
              bias_cnt_d = 8'h00;
              panel_d.backplane_bias_toggle = ~panel_q.backplane_bias_toggle; // [R9]
            end else begin
              bias_cnt_d = bias_cnt_q + 8'h01;
            end
            if (last_line) begin
              line_d = '0;
              // The first frame end only arms the count, so blanking lands one to two frames on.
              if (config_in.power_save) begin
                if (save_frames_q != 2'h2) begin
                  save_frames_d = save_frames_q + 2'h1;
                end
                if (save_frames_q >= 2'h1) begin
                  panel_d.row_drive_disable_n = 1'b0; // [R14]
                end
              end else begin
                save_frames_d = 2'h0;
                // Disable rises only at a frame end, so the row drivers never start mid-scan.
                panel_d.row_drive_disable_n = 1'b1; // [R13]
              end
            end else begin
              line_d = line_q + LW'(1);
            end
          end
        end
        default: begin
          state_d = LPD_ST_START;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= LPD_ST_START; // [R1]
      div_q <= 4'h0;
      half_b_q <= 1'b0;
      col_q <= '0;
      line_q <= '0;
      bias_cnt_q <= 8'h00;
      save_frames_q <= 2'h0;
      take_q <= 1'b0;
      panel_q.column_data_out <= `LPD_RST_DATA; // [R2]
      panel_q.column_shift_clock <= `LPD_RST_LEVEL;
      panel_q.column_enable_chain_clock <= `LPD_RST_LEVEL;
      panel_q.line_latch_pulse <= `LPD_RST_LEVEL;
      panel_q.backplane_bias_toggle <= `LPD_RST_LEVEL;
      panel_q.row_shift_clock <= `LPD_RST_LEVEL;
      panel_q.frame_row_pulse <= `LPD_RST_LEVEL;
      panel_q.row_drive_disable_n <= `LPD_RST_DISABLE_N; // [R15]
    end else if (clk_en) begin
      state_q <= state_d;
      div_q <= div_d;
      half_b_q <= half_b_d;
      col_q <= col_d;
      line_q <= line_d;
      bias_cnt_q <= bias_cnt_d;
      save_frames_q <= save_frames_d;
      take_q <= take_d;
      panel_q <= panel_d;
    end
  end

  // The row drivers shift the frame pulse themselves on each row clock fall.
  // [R12]
  assign panel = panel_q;
  // The enable masks the take pulse, so a frozen cycle never asks for a second nibble.
  assign pixel_take = take_q & clk_en;

endmodule : lpd_panel_timing

// File: lpd_params.svh
// Constant definitions for the panel drive timing block.
`ifndef LPD_PARAMS_SVH
`define LPD_PARAMS_SVH

// Strap codes selecting the column shift clock ratio.
`define LPD_STRAP_DIV4 2'h0
`define LPD_STRAP_DIV8 2'h1
`define LPD_STRAP_DIV16 2'h2
`define LPD_STRAP_RSVD 2'h3

// Half periods of the column shift clock in system clocks.
`define LPD_HALF_DIV4 4'h2
`define LPD_HALF_DIV8 4'h4
`define LPD_HALF_DIV16 4'h8

// Shift pulses served by one column driver before the enable moves on.
`define LPD_ENABLE_GROUP 16

// Default panel geometry: nibbles per line and lines per frame.
`define LPD_COLS_DEFAULT 80
`define LPD_LINES_DEFAULT 240

// Reset values of the panel outputs.
`define LPD_RST_DATA 4'h0
`define LPD_RST_LEVEL 1'b0
`define LPD_RST_DISABLE_N 1'b0
`define LPD_RST_BIAS_PERIOD 8'h01

`endif

// File: lpd_pkg.sv
// Types shared by the panel drive timing block.
package lpd_pkg;

  typedef enum logic [1:0] {
    LPD_ST_START,
    LPD_ST_SHIFT,
    LPD_ST_LATCH
  } lpd_state_type;

  typedef struct packed {
    logic [3:0] column_data_out;
    logic column_shift_clock;
    logic column_enable_chain_clock;
    logic line_latch_pulse;
    logic backplane_bias_toggle;
    logic row_shift_clock;
    logic frame_row_pulse;
    logic row_drive_disable_n;
  } lpd_panel_type;

  typedef struct packed {
    logic power_save;
    logic [7:0] bias_period;
  } lpd_config_type;

endpackage : lpd_pkg

// File: lpd_properties.sv
// Concurrent checks on the panel drive outputs.
`timescale 1ns/1ps
module lpd_properties #(
  parameter int COLS = 80,
  parameter int LINES = 240
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire lpd_pkg::lpd_panel_type panel
);
  import lpd_pkg::*;
  int nf_q;
  int ln_q;
  wire sh = panel.column_shift_clock;
  wire lat = panel.line_latch_pulse;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // The fall count restarts at each latch, so every line is judged on its own.
  always_ff @(posedge clk) begin
    nf_q <= (!rst_n || lat) ? 0 : nf_q + int'($fell(sh));
    ln_q <= !rst_n ? 0 : ($fell(lat) ? (ln_q + 1) % LINES : ln_q);
  end
  data_hold_a: assert property ($fell(sh) |-> $stable(panel.column_data_out)) else $error("data");
  shift_idle_a: assert property (lat |-> !sh) else $error("idle");
  enable_step_a: assert property ($rose(panel.column_enable_chain_clock) |->
    nf_q == 0 || (nf_q + 1) % 16 == 0) else $error("enable");
  latch_count_a: assert property ($rose(lat) |-> nf_q == COLS) else $error("count");
  row_clock_a: assert property (panel.row_shift_clock == lat) else $error("row");
  frame_last_a: assert property ($rose(lat) |->
    panel.frame_row_pulse == (ln_q == LINES - 1)) else $error("frame");
  bias_step_a: assert property ($changed(panel.backplane_bias_toggle) |-> $fell(lat)) else $error("bias");
  off_step_a: assert property ($changed(panel.row_drive_disable_n) |-> $fell(lat)) else $error("off");
  line_c: cover property ($fell(lat));
  frame_c: cover property ($rose(panel.frame_row_pulse));
  save_c: cover property ($fell(panel.row_drive_disable_n));
endmodule : lpd_properties
bind lpd_panel_timing lpd_properties #(.COLS(COLS), .LINES(LINES)) chk (.clk(clk), .rst_n(rst_n), .panel(panel));

// File: lpd_drv.sv
// Behavioural column and row driver chain of the panel.
`timescale 1ns/1ps
module lpd_drv #(
  parameter int COLS = 20,
  parameter int LINES = 4
) (
  input wire logic clk,
  input wire lpd_pkg::lpd_panel_type panel,
  output int bad,
  output logic [LINES-1:0] rows_q
);
  import lpd_pkg::*;
  lpd_panel_type p_q;
  int got_q = 0;
  int ecl_q = 0;
  int bad_q = 0;
  logic [3:0] want_q = 4'h0;
  assign bad = bad_q;
  always @(posedge clk) begin
    p_q <= panel;
    if (p_q.column_shift_clock && !panel.column_shift_clock) begin
      bad_q <= bad_q + int'(panel.column_data_out !== want_q);
      want_q <= want_q + 4'h1;
      got_q <= got_q + 1;
    end
    // Each column driver takes 16 nibbles, and the cascade restarts before every line.
    if (p_q.column_enable_chain_clock && !panel.column_enable_chain_clock) begin
      bad_q <= bad_q + int'(got_q % 16 != 0);
      ecl_q <= ecl_q + 1;
    end
    if (p_q.line_latch_pulse && !panel.line_latch_pulse) begin
      bad_q <= bad_q + int'(got_q != COLS || ecl_q != 1 + COLS / 16);
      got_q <= 0;
      ecl_q <= 0;
    end
    if (p_q.row_shift_clock && !panel.row_shift_clock) rows_q <= {rows_q[LINES-2:0], panel.frame_row_pulse};
  end
endmodule : lpd_drv

// File: testbench.sv
// Self-checking bench for the panel drive timing block.
`timescale 1ns/1ps
module testbench;
  import lpd_pkg::*;
  localparam int C = 20, L = 4, LN = (4 + 2 * C) * 2, FR = L * LN;
  logic clk, rst_n, take, en;
  logic [1:0] strap;
  logic [3:0] nib, rows;
  lpd_config_type cfg;
  lpd_panel_type p;
  int bad, n_errors, compares;
  lpd_panel_timing #(.COLS(C), .LINES(L)) uut (.clk(clk), .rst_n(rst_n), .clk_en(en), .strap_config(strap),
    .scan_test_enable_in(1'b0), .test_mode_enable_in(1'b0), .config_in(cfg), .pixel_nibble(nib),
    .pixel_take(take), .panel(p));
  lpd_drv #(.COLS(C), .LINES(L)) drv (.clk(clk), .panel(p), .bad(bad), .rows_q(rows));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(negedge clk) if (take === 1'b1) nib <= nib + 4'h1;
  task chk(input bit ok, input string m);
    compares++;
    if (!ok) begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task wb(input int s, input logic v, output int n);
    for (n = 0; p[s] !== v && n < 9999; n++) @(negedge clk);
    if (n == 9999) chk(0, "hang");
  endtask : wb
  task t_reset;
    repeat (12) begin
      @(posedge clk);
      @(negedge clk);
      chk(p === '0 && take === 1'b0, "reset");
    end
    rst_n = 1'b1;
  endtask : t_reset
  task t_ratio;
    int n;
    for (int c = 0; c < 4; c++) begin
      strap = c[1:0];
      for (int k = 0; k < 4; k++) wb(4, k[0] == 0, n);
      wb(6, 1'b1, n);
      wb(6, 1'b0, n);
      chk(2 * n == (c == 0 ? 4 : c == 1 ? 8 : 16), "ratio");
    end
    strap = 2'h0;
  endtask : t_ratio
  task t_bias;
    int n;
    for (int b = 0; b < 4; b += 3) begin
      cfg.bias_period = b[7:0];
      repeat (3) wb(3, !p[3], n);
      chk(n == (b == 0 ? 1 : b) * LN, "bias");
    end
  endtask : t_bias
  task t_power;
    int n;
    chk(p.row_drive_disable_n === 1'b1, "on");
    cfg.power_save = 1'b1;
    wb(0, 1'b0, n);
    chk(n > FR && n <= 2 * FR, "save");
    cfg.power_save = 1'b0;
    wb(0, 1'b1, n);
    chk(n == FR, "wake");
  endtask : t_power
  task t_freeze;
    lpd_panel_type q;
    @(negedge clk);
    while (take === 1'b1) @(negedge clk);
    q = p;
    en = 1'b0;
    repeat (10) begin
      @(negedge clk);
      chk(p === q && take === 1'b0, "freeze");
    end
    en = 1'b1;
  endtask : t_freeze
  task t_chain;
    chk(bad === 0 && $onehot(rows), "chain");
  endtask : t_chain
  task stop_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  initial begin
    {n_errors, compares, nib, strap, cfg, rst_n} = '0;
    en = 1'b1;
    t_reset();
    t_ratio();
    t_freeze();
    t_bias();
    t_power();
    t_chain();
    stop_test();
  end
  // The limit is several times the longest expected run, so only a real hang trips it.
  initial begin
    #300000;
    n_errors++;
    stop_test();
  end
endmodule : testbench
